// *** hw/psm_defines.svh ***
// register indices, field positions, reset values and write masks
// assumes: included by the top module and its assertion checker only
`ifndef PSM_DEFINES_SVH
`define PSM_DEFINES_SVH

// register index; byte address on the bus is four times the index
`define PSM_IDX_SEL_A 16'hff00
`define PSM_IDX_SEL_B 16'hff01
`define PSM_IDX_SEL_C 16'hff02
`define PSM_IDX_DIR5 16'hff03
`define PSM_IDX_DIR6 16'hff04
`define PSM_IDX_DIR7 16'hff05

// pin_function_select_a fields
`define PSM_A_SECOND_DDC 6
`define PSM_A_PWM_MSB 5
// pin_function_select_b fields
`define PSM_B_ANALOG_ROUTE 7
`define PSM_B_DIGITAL_ROUTE 6
`define PSM_B_IRQ_ONE 2
`define PSM_B_CLK_TWO 1
`define PSM_B_FIRST_DDC 0
// pin_function_select_c fields
`define PSM_C_CLK_ONE 4
`define PSM_C_ANALOG_MSB 3
// port7_direction fields
`define PSM_D7_BIT7 7
`define PSM_D7_BIT6 6

// reset values
`define PSM_RST_SEL_A 8'h40
`define PSM_RST_SEL_B 8'h45
`define PSM_RST_SEL_C 8'h00
`define PSM_RST_DIR5 8'h00
`define PSM_RST_DIR6 8'h00
`define PSM_RST_DIR7 8'h00

// implemented bits; all others are reserved
`define PSM_MASK_SEL_A 8'h7f
`define PSM_MASK_SEL_B 8'hc7
`define PSM_MASK_SEL_C 8'h1f
`define PSM_MASK_DIR5 8'hff
`define PSM_MASK_DIR6 8'hff
`define PSM_MASK_DIR7 8'hc0

// pad vector layout
`define PSM_NPAD 21
`define PSM_PAD_P6 8
`define PSM_PAD_P76 16
`define PSM_PAD_P77 17
`define PSM_PAD_P30 18
`define PSM_PAD_P31 19
`define PSM_PAD_P33 20

`endif

// *** hw/psm_pkg.sv ***
// types shared by the pin-share block and its pad cells
// assumes: constants come from psm_defines.svh
package psm_pkg;

    // one pad drive: value and output enable
    typedef struct packed {
        logic out;
        logic oe;
    } psm_pad_type;

    // a display ddc port: per line either pull-low request or sensed level
    typedef struct packed {
        logic scl;
        logic sda;
    } psm_ddc_type;

endpackage

// *** hw/psm_pad_cell.sv ***
// one shared pad: input synchroniser and registered drive select
// assumes: pad_in is asynchronous to clk
module psm_pad_cell
    import psm_pkg::*;
(
    input logic clk,
    input logic rst,
    input logic pad_in,
    input logic alt_sel,
    input psm_pad_type alt_drive,
    input psm_pad_type gp_drive,
    output psm_pad_type pad_drive,
    output logic level
);

    logic sync_first;
    logic sync_second;
    psm_pad_type drive;
    psm_pad_type next_drive;

    // first stage feeds the second only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_first <= 1'b1;
            sync_second <= 1'b1;
        end else begin
            sync_first <= pad_in;
            sync_second <= sync_first;
        end
    end

    // peripheral owns the pad when selected, else port bit and direction
    always_comb begin
        next_drive = alt_sel ? alt_drive : gp_drive; // [R16]
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive <= '0;
        end else begin
            drive <= next_drive;
        end
    end

    assign pad_drive = drive;
    assign level = sync_second;

endmodule

// *** hw/psm_top.sv ***
// pin-share and port direction block behind a classic wishbone slave
// assumes: core supplies port data bits and peripheral drive signals
// Contract
// [R1] select_a bit 6 picks port 5.6/5.7 or second ddc pair; reset 1
// [R2] select_a bits 5..0 pick port 5.n or pwm output n; reset 0
// [R3] select_b bit 7 routes analog ddc port to first or second pair
// [R4] select_b bit 6 routes digital ddc port likewise; resets to 1
// [R5] select_b bit 2 connects pin 3.3 to interrupt one; reset 1
// [R6] software clears the interrupt connect bit before using 3.3 as port
// [R7] select_b bit 1 picks port 7.6 or clock output two; reset 0
// [R8] select_b bit 0 picks port 3.0/3.1 serial or first ddc pair; reset 1
// [R9] select_c bit 4 picks port 6.6 or clock output one; reset 0
// [R10] select_c bits 3..0 pick port 6.n or analog input n; reset 0
// [R11] port 5 direction bit n: 0 input, 1 output; reset input
// [R12] port 6 direction bit n: 0 input, 1 output; reset input
// [R13] port 7 direction bit 7 sets pin 7.7 direction; reset input
// [R14] port 7 direction bit 6 sets pin 7.6; bits 5..0 reserved
// [R15] reserved bits read zero and ignore writes
// [R16] a selected alternate function, not the port, drives the pin
`include "psm_defines.svh"

module psm_top
    import psm_pkg::*;
(
    input logic clk,
    input logic rst,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic [17:0] wb_adr_i,
    input logic [3:0] wb_sel_i,
    input logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input logic [7:0] port5_pin_in,
    output logic [7:0] port5_pin_out,
    output logic [7:0] port5_pin_oe,
    input logic [7:0] port6_pin_in,
    output logic [7:0] port6_pin_out,
    output logic [7:0] port6_pin_oe,
    input logic [7:6] port7_pin_in,
    output logic [7:6] port7_pin_out,
    output logic [7:6] port7_pin_oe,
    input logic [2:0] port3_pin_in,
    output logic [2:0] port3_pin_out,
    output logic [2:0] port3_pin_oe,
    input logic [7:0] port5_data,
    input logic [7:0] port6_data,
    input logic [7:6] port7_data,
    input logic [2:0] port3_data,
    output logic [7:0] port5_level,
    output logic [7:0] port6_level,
    output logic [7:6] port7_level,
    output logic [2:0] port3_level,
    input logic [5:0] pwm_wave,
    input logic clock_output_one_src,
    input logic clock_output_two_src,
    input logic uart_txd,
    output logic uart_rxd,
    input psm_ddc_type analog_ddc_pull,
    input psm_ddc_type digital_ddc_pull,
    output psm_ddc_type analog_ddc_sense,
    output psm_ddc_type digital_ddc_sense,
    output logic external_interrupt_one,
    output logic [3:0] analog_in_enable
);

    logic [7:0] sel_a;
    logic [7:0] sel_b;
    logic [7:0] sel_c;
    logic [7:0] dir5;
    logic [7:0] dir6;
    logic [7:0] dir7;
    logic [7:0] next_sel_a;
    logic [7:0] next_sel_b;
    logic [7:0] next_sel_c;
    logic [7:0] next_dir5;
    logic [7:0] next_dir6;
    logic [7:0] next_dir7;

    logic ack;
    logic [31:0] rdata;
    logic next_ack;
    logic [31:0] next_rdata;
    logic take;
    logic wr_byte;
    logic [15:0] idx;

    logic [`PSM_NPAD-1:0] pad_in;
    logic [`PSM_NPAD-1:0] pad_sel;
    logic [`PSM_NPAD-1:0] pad_level;
    psm_pad_type [`PSM_NPAD-1:0] pad_alt;
    psm_pad_type [`PSM_NPAD-1:0] pad_gp;
    psm_pad_type [`PSM_NPAD-1:0] pad_drive;

    psm_ddc_type pull_first;
    psm_ddc_type pull_second;
    psm_ddc_type first_level;
    psm_ddc_type second_level;

    logic rxd;
    logic irq_one;
    logic [3:0] ana_en;
    psm_ddc_type ana_sense;
    psm_ddc_type dig_sense;
    logic next_rxd;
    logic next_irq_one;
    logic [3:0] next_ana_en;
    psm_ddc_type next_ana_sense;
    psm_ddc_type next_dig_sense;

    // bus request and register file
    assign idx = wb_adr_i[17:2];
    assign take = wb_cyc_i & wb_stb_i & ~ack;
    assign wr_byte = take & wb_we_i & wb_sel_i[0];

    always_comb begin
        next_ack = take;
        next_rdata = '0;
        next_sel_a = sel_a;
        next_sel_b = sel_b;
        next_sel_c = sel_c;
        next_dir5 = dir5;
        next_dir6 = dir6;
        next_dir7 = dir7;
        // unmapped indices answer with zero data and still ack
        unique case (idx)
            `PSM_IDX_SEL_A: begin
                next_rdata[7:0] = sel_a;
                if (wr_byte) begin
                    next_sel_a = wb_dat_i[7:0] & `PSM_MASK_SEL_A; // [R1] [R2]
                end
            end
            `PSM_IDX_SEL_B: begin
                next_rdata[7:0] = sel_b;
                if (wr_byte) begin
                    // [R3] [R4] [R5] [R7] [R8]
                    next_sel_b = wb_dat_i[7:0] & `PSM_MASK_SEL_B;
                end
            end
            `PSM_IDX_SEL_C: begin
                next_rdata[7:0] = sel_c;
                if (wr_byte) begin
                    next_sel_c = wb_dat_i[7:0] & `PSM_MASK_SEL_C; // [R9] [R10]
                end
            end
            `PSM_IDX_DIR5: begin
                next_rdata[7:0] = dir5;
                if (wr_byte) begin
                    next_dir5 = wb_dat_i[7:0] & `PSM_MASK_DIR5; // [R11]
                end
            end
            `PSM_IDX_DIR6: begin
                next_rdata[7:0] = dir6;
                if (wr_byte) begin
                    next_dir6 = wb_dat_i[7:0] & `PSM_MASK_DIR6; // [R12]
                end
            end
            `PSM_IDX_DIR7: begin
                next_rdata[7:0] = dir7;
                if (wr_byte) begin
                    // reserved low bits masked off [R13] [R14] [R15]
                    next_dir7 = wb_dat_i[7:0] & `PSM_MASK_DIR7;
                end
            end
            default: begin
                next_rdata = '0;
            end
        endcase
        if (!take) begin
            next_rdata = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
            rdata <= '0;
            sel_a <= `PSM_RST_SEL_A; // [R1] [R2]
            sel_b <= `PSM_RST_SEL_B; // [R3] [R4] [R5] [R7] [R8]
            sel_c <= `PSM_RST_SEL_C; // [R9] [R10]
            dir5 <= `PSM_RST_DIR5; // [R11]
            dir6 <= `PSM_RST_DIR6; // [R12]
            dir7 <= `PSM_RST_DIR7; // [R13] [R14]
        end else begin
            ack <= next_ack;
            rdata <= next_rdata;
            sel_a <= next_sel_a;
            sel_b <= next_sel_b;
            sel_c <= next_sel_c;
            dir5 <= next_dir5;
            dir6 <= next_dir6;
            dir7 <= next_dir7;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;

    // ddc pull-low merged per pair; both ports on one pair wire-and
    always_comb begin
        pull_first.scl = (~sel_b[`PSM_B_ANALOG_ROUTE] & analog_ddc_pull.scl)
            | (~sel_b[`PSM_B_DIGITAL_ROUTE] & digital_ddc_pull.scl);
        pull_first.sda = (~sel_b[`PSM_B_ANALOG_ROUTE] & analog_ddc_pull.sda)
            | (~sel_b[`PSM_B_DIGITAL_ROUTE] & digital_ddc_pull.sda);
        pull_second.scl = (sel_b[`PSM_B_ANALOG_ROUTE] & analog_ddc_pull.scl)
            | (sel_b[`PSM_B_DIGITAL_ROUTE] & digital_ddc_pull.scl);
        pull_second.sda = (sel_b[`PSM_B_ANALOG_ROUTE] & analog_ddc_pull.sda)
            | (sel_b[`PSM_B_DIGITAL_ROUTE] & digital_ddc_pull.sda);
    end

    // per-pad function select, alternate drive and port drive
    always_comb begin
        pad_in = {port3_pin_in, port7_pin_in, port6_pin_in, port5_pin_in};
        pad_sel = '0;
        for (int n = 0; n < 8; n++) begin
            pad_gp[n] = '{out: port5_data[n], oe: dir5[n]}; // [R11]
            pad_gp[`PSM_PAD_P6 + n] = '{out: port6_data[n], oe: dir6[n]}; // [R12]
        end
        for (int n = 0; n < 6; n++) begin
            pad_sel[n] = sel_a[n]; // [R2]
            pad_alt[n] = '{out: pwm_wave[n], oe: 1'b1};
        end
        pad_sel[6] = sel_a[`PSM_A_SECOND_DDC]; // [R1]
        pad_sel[7] = sel_a[`PSM_A_SECOND_DDC];
        pad_alt[6] = '{out: 1'b0, oe: pull_second.scl}; // [R3] [R4]
        pad_alt[7] = '{out: 1'b0, oe: pull_second.sda};
        for (int n = 0; n < 8; n++) begin
            pad_alt[`PSM_PAD_P6 + n] = '0;
        end
        for (int n = 0; n < 4; n++) begin
            // analog channel: pad released, digital driver off [R10]
            pad_sel[`PSM_PAD_P6 + n] = sel_c[n];
        end
        pad_sel[`PSM_PAD_P6 + 6] = sel_c[`PSM_C_CLK_ONE]; // [R9]
        pad_alt[`PSM_PAD_P6 + 6] = '{out: clock_output_one_src, oe: 1'b1};
        pad_gp[`PSM_PAD_P76] = '{out: port7_data[6],
                                 oe: dir7[`PSM_D7_BIT6]}; // [R14]
        pad_gp[`PSM_PAD_P77] = '{out: port7_data[7],
                                 oe: dir7[`PSM_D7_BIT7]}; // [R13]
        pad_sel[`PSM_PAD_P76] = sel_b[`PSM_B_CLK_TWO]; // [R7]
        pad_alt[`PSM_PAD_P76] = '{out: clock_output_two_src, oe: 1'b1};
        pad_alt[`PSM_PAD_P77] = '0;
        // port 3 is quasi-bidirectional: drives only its low level
        pad_gp[`PSM_PAD_P30] = '{out: 1'b0, oe: ~port3_data[0]};
        pad_gp[`PSM_PAD_P31] = '{out: 1'b0, oe: ~(port3_data[1] & uart_txd)};
        pad_gp[`PSM_PAD_P33] = '{out: 1'b0, oe: ~port3_data[2]};
        pad_sel[`PSM_PAD_P30] = sel_b[`PSM_B_FIRST_DDC]; // [R8]
        pad_sel[`PSM_PAD_P31] = sel_b[`PSM_B_FIRST_DDC];
        pad_alt[`PSM_PAD_P30] = '{out: 1'b0, oe: pull_first.scl}; // [R3] [R4]
        pad_alt[`PSM_PAD_P31] = '{out: 1'b0, oe: pull_first.sda};
        pad_alt[`PSM_PAD_P33] = '0;
    end

    genvar g;
    generate
        for (g = 0; g < `PSM_NPAD; g++) begin : gen_pad
            psm_pad_cell u_pad (
                .clk(clk),
                .rst(rst),
                .pad_in(pad_in[g]),
                .alt_sel(pad_sel[g]),
                .alt_drive(pad_alt[g]),
                .gp_drive(pad_gp[g]),
                .pad_drive(pad_drive[g]),
                .level(pad_level[g])
            );
        end
    endgenerate

    // sensed levels handed to the peripherals; idle high when unrouted
    always_comb begin
        first_level.scl = sel_b[`PSM_B_FIRST_DDC] ?
            pad_level[`PSM_PAD_P30] : 1'b1;
        first_level.sda = sel_b[`PSM_B_FIRST_DDC] ?
            pad_level[`PSM_PAD_P31] : 1'b1;
        second_level.scl = sel_a[`PSM_A_SECOND_DDC] ? pad_level[6] : 1'b1;
        second_level.sda = sel_a[`PSM_A_SECOND_DDC] ? pad_level[7] : 1'b1;
        // [R3]
        next_ana_sense = sel_b[`PSM_B_ANALOG_ROUTE] ? second_level
                                                     : first_level;
        // [R4]
        next_dig_sense = sel_b[`PSM_B_DIGITAL_ROUTE] ? second_level
                                                      : first_level;
        // receiver sees idle high while the pair serves ddc [R8]
        next_rxd = sel_b[`PSM_B_FIRST_DDC] ? 1'b1 : pad_level[`PSM_PAD_P30];
        // disconnected input is held inactive high so no spurious edge [R5]
        next_irq_one = sel_b[`PSM_B_IRQ_ONE] ? pad_level[`PSM_PAD_P33] : 1'b1;
        next_ana_en = sel_c[`PSM_C_ANALOG_MSB:0]; // [R10]
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ana_sense <= '1;
            dig_sense <= '1;
            rxd <= 1'b1;
            irq_one <= 1'b1;
            ana_en <= '0;
        end else begin
            ana_sense <= next_ana_sense;
            dig_sense <= next_dig_sense;
            rxd <= next_rxd;
            irq_one <= next_irq_one;
            ana_en <= next_ana_en;
        end
    end

    // clock outputs pass a pad flop: only clocks well below clk/2 survive
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            port5_pin_out[n] = pad_drive[n].out;
            port5_pin_oe[n] = pad_drive[n].oe;
            port6_pin_out[n] = pad_drive[`PSM_PAD_P6 + n].out;
            port6_pin_oe[n] = pad_drive[`PSM_PAD_P6 + n].oe;
        end
        port7_pin_out = {pad_drive[`PSM_PAD_P77].out,
                         pad_drive[`PSM_PAD_P76].out};
        port7_pin_oe = {pad_drive[`PSM_PAD_P77].oe,
                        pad_drive[`PSM_PAD_P76].oe};
        port3_pin_out = {pad_drive[`PSM_PAD_P33].out,
                         pad_drive[`PSM_PAD_P31].out,
                         pad_drive[`PSM_PAD_P30].out};
        port3_pin_oe = {pad_drive[`PSM_PAD_P33].oe,
                        pad_drive[`PSM_PAD_P31].oe,
                        pad_drive[`PSM_PAD_P30].oe};
    end

    // port 3.3 level always reaches the core; software must clear the
    // interrupt connect bit itself when using it as a port [R6]
    assign port5_level = pad_level[7:0];
    assign port6_level = pad_level[15:8];
    assign port7_level = pad_level[17:16];
    assign port3_level = pad_level[20:18];
    assign analog_ddc_sense = ana_sense;
    assign digital_ddc_sense = dig_sense;
    assign uart_rxd = rxd;
    assign external_interrupt_one = irq_one;
    assign analog_in_enable = ana_en;

endmodule

// *** verif/psm_top_assertions.sv ***
// checker for the pin-share block, bound to every psm_top instance
// assumes: a register is written at the edge that takes the request
`include "psm_defines.svh"
module psm_top_assertions (
    input logic clk,
    input logic rst,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic [17:0] wb_adr_i,
    input logic [3:0] wb_sel_i,
    input logic [31:0] wb_dat_i,
    input logic [31:0] wb_dat_o,
    input logic wb_ack_o,
    input logic [7:0] port5_pin_out,
    input logic [7:0] port5_pin_oe,
    input logic [7:0] port6_pin_oe,
    input logic [7:6] port7_pin_oe,
    input logic [5:0] pwm_wave,
    input logic external_interrupt_one,
    input logic [3:0] analog_in_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] idx;
    logic take_wr;
    logic wr_ack;
    logic [7:0] sel_a, sel_b, next_sel_a, next_sel_b;
    assign idx = wb_adr_i[17:2];
    assign take_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
    assign wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
    // shadow of the two select registers, so pin routing can be judged
    always_comb begin
        next_sel_a = sel_a;
        next_sel_b = sel_b;
        if (take_wr && idx == `PSM_IDX_SEL_A)
            next_sel_a = wb_dat_i[7:0] & `PSM_MASK_SEL_A;
        if (take_wr && idx == `PSM_IDX_SEL_B)
            next_sel_b = wb_dat_i[7:0] & `PSM_MASK_SEL_B;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_a <= `PSM_RST_SEL_A;
            sel_b <= `PSM_RST_SEL_B;
        end else begin
            sel_a <= next_sel_a;
            sel_b <= next_sel_b;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_ack_one;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack late");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data idle");
    property p_reserved;
        wb_ack_o && !wb_we_i && idx == `PSM_IDX_DIR7 |-> wb_dat_o[5:0] == 6'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits");
    property p_pwm;
        ((port5_pin_out[5:0] ^ $past(pwm_wave)) & $past(sel_a[5:0])) == 6'h0
            && (port5_pin_oe[5:0] & $past(sel_a[5:0])) == $past(sel_a[5:0]);
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm routing");
    property p_second_pair;
        $past(sel_a[6]) |-> port5_pin_out[7:6] == 2'b00;
    endproperty
    a_second_pair: assert property (p_second_pair) else $error("ddc pair");
    property p_analog;
        wr_ack && idx == `PSM_IDX_SEL_C |=> analog_in_enable == $past(wb_dat_i[3:0]);
    endproperty
    a_analog: assert property (p_analog) else $error("analog enable");
    property p_dir6;
        wr_ack && idx == `PSM_IDX_DIR6 |=> port6_pin_oe[7] == $past(wb_dat_i[7])
            && port6_pin_oe[5:4] == $past(wb_dat_i[5:4]);
    endproperty
    a_dir6: assert property (p_dir6) else $error("port6 direction");
    property p_dir7;
        wr_ack && idx == `PSM_IDX_DIR7 |=> port7_pin_oe[7] == $past(wb_dat_i[7]);
    endproperty
    a_dir7: assert property (p_dir7) else $error("port7 direction");
    property p_irq_off;
        !$past(sel_b[2]) |-> external_interrupt_one;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq isolation");
endmodule

bind psm_top psm_top_assertions u_chk (.clk(clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port5_pin_out(port5_pin_out),
    .port5_pin_oe(port5_pin_oe), .port6_pin_oe(port6_pin_oe),
    .port7_pin_oe(port7_pin_oe), .pwm_wave(pwm_wave),
    .external_interrupt_one(external_interrupt_one),
    .analog_in_enable(analog_in_enable));

// *** verif/psm_pad_model.sv ***
// package pins around the block: pad drive, pull-up, outside pull-low
// assumes: p5 in bits 7..0, p6, p7.6/7.7, then p3.0/3.1/3.3 on top
module psm_pad_model (
    input logic [20:0] pad_out,
    input logic [20:0] pad_oe,
    input logic [20:0] ext_low,
    output logic [20:0] level
);
    timeunit 1ns;
    timeprecision 1ps;
    // outside parts only pull low, so the wire is and-ed like open drain
    assign level = ~ext_low & (~pad_oe | pad_out);
endmodule

// *** verif/test_pin_share_and_port_direction.sv ***
// self-checking bench for the pin-share block and its pins
// assumes: one 125 MHz clock, registers one byte each in the low lane
module test_pin_share_and_port_direction
    import psm_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack_o;
    logic [17:0] wb_adr = '0;
    logic [3:0] wb_sel = '0;
    logic [31:0] wb_dat = '0, wb_dat_o, q;
    logic [7:0] p5_out, p5_oe, p6_out, p6_oe, p5_data = 0, p6_data = 0;
    logic [7:6] p7_out, p7_oe, p7_data = 0;
    logic [2:0] p3_out, p3_oe, p3_data = 3'b111;
    logic [20:0] lvl, ext_low = '0;
    wire [20:0] plvl;
    logic [5:0] pwm = 0;
    logic [3:0] ain;
    logic ck1 = 0, ck2 = 0, txd = 1, rxd, irq;
    psm_ddc_type a_pull = '0, d_pull = '0, a_sense, d_sense;
    int n_mismatch = 0, n_tests = 0;
    always #4 clk = ~clk;
    psm_top u_dut (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port5_pin_in(lvl[7:0]),
        .port5_pin_out(p5_out), .port5_pin_oe(p5_oe), .port6_pin_in(lvl[15:8]),
        .port6_pin_out(p6_out), .port6_pin_oe(p6_oe), .port7_pin_in(lvl[17:16]),
        .port7_pin_out(p7_out), .port7_pin_oe(p7_oe), .port3_pin_in(lvl[20:18]),
        .port3_pin_out(p3_out), .port3_pin_oe(p3_oe), .port5_data(p5_data),
        .port6_data(p6_data), .port7_data(p7_data), .port3_data(p3_data),
        .port5_level(plvl[7:0]), .port6_level(plvl[15:8]),
        .port7_level(plvl[17:16]), .port3_level(plvl[20:18]),
        .pwm_wave(pwm), .clock_output_one_src(ck1), .clock_output_two_src(ck2),
        .uart_txd(txd), .uart_rxd(rxd), .analog_ddc_pull(a_pull),
        .digital_ddc_pull(d_pull), .analog_ddc_sense(a_sense),
        .digital_ddc_sense(d_sense), .external_interrupt_one(irq),
        .analog_in_enable(ain));
    psm_pad_model u_pads (.pad_out({p3_out, p7_out, p6_out, p5_out}),
        .pad_oe({p3_oe, p7_oe, p6_oe, p5_oe}), .ext_low(ext_low), .level(lvl));
    task automatic chk(input string what, input logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    // one classic cycle; read data taken at the rising edge that sees ack
    // no local count: a hang is ended by the watchdog
    task automatic xfer(input logic w, logic [15:0] idx, logic [7:0] d, logic s);
        @(posedge clk);
        wb_cyc <= 1;
        wb_stb <= 1;
        wb_we <= w;
        wb_adr <= {idx, 2'b00};
        wb_sel <= {3'b000, s};
        wb_dat <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc <= 0;
        wb_stb <= 0;
    endtask
    task automatic wr(input logic [15:0] idx, logic [7:0] d);
        xfer(1'b1, idx, d, 1'b1);
    endtask
    task automatic rd(input string what, logic [15:0] idx, logic [7:0] e);
        xfer(1'b0, idx, 8'h00, 1'b1);
        chk(what, {24'h0, e}, q);
    endtask
    // pins follow one edge later, synchronised levels three
    task automatic settle;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic t_reset;
        logic [7:0] rv [6] = '{8'h40, 8'h45, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++)
            rd("reset value", 16'hff00 + 16'(i), rv[i]);
        $display("reset values done");
    endtask
    task automatic t_regs;
        logic [7:0] mk [6] = '{8'h7f, 8'hc7, 8'h1f, 8'hff, 8'hff, 8'hc0};
        for (int i = 0; i < 6; i++) begin
            wr(16'hff00 + 16'(i), 8'hff);
            rd("ones", 16'hff00 + 16'(i), mk[i]);
            wr(16'hff00 + 16'(i), 8'h00);
            rd("zeros", 16'hff00 + 16'(i), 8'h00);
        end
        xfer(1'b1, 16'hff03, 8'h5a, 1'b0);
        rd("lane off", 16'hff03, 8'h00);
        rd("unmapped", 16'hff06, 8'h00);
        $display("register access done");
    endtask
    task automatic t_pwm;
        pwm <= 6'h2a;
        wr(16'hff00, 8'h3f);
        settle;
        chk("pwm drive", 32'h2a, {26'h0, p5_out[5:0]});
        chk("pwm enable", 32'h3f, {26'h0, p5_oe[5:0]});
        wr(16'hff00, 8'h00);
        wr(16'hff03, 8'h8f);
        settle;
        chk("port5 enable", 32'h8f, {24'h0, p5_oe});
        $display("pwm routing done");
    endtask
    task automatic t_analog;
        wr(16'hff04, 8'hff);
        wr(16'hff02, 8'h0f);
        settle;
        chk("analog enable", 32'hf, {28'h0, ain});
        chk("port6 enable", 32'hf0, {24'h0, p6_oe});
        $display("analog inputs done");
    endtask
    task automatic t_clock;
        wr(16'hff04, 8'h00);
        wr(16'hff02, 8'h10);
        wr(16'hff01, 8'h02);
        ck1 <= 1;
        ck2 <= 1;
        settle;
        chk("clocks high", 32'hf, {28'h0, p6_out[6], p6_oe[6], p7_out[6],
            p7_oe[6]});
        @(posedge clk);
        ck1 <= 0;
        ck2 <= 0;
        settle;
        chk("clocks low", 32'h5, {28'h0, p6_out[6], p6_oe[6], p7_out[6],
            p7_oe[6]});
        $display("clock outputs done");
    endtask
    task automatic t_irq;
        wr(16'hff01, 8'h45);
        ext_low[20] <= 1;
        settle;
        chk("irq connected", 32'h0, {31'h0, irq});
        chk("pin levels", {11'h0, lvl}, {11'h0, plvl});
        wr(16'hff01, 8'h41);
        settle;
        chk("irq isolated", 32'h1, {31'h0, irq});
        @(posedge clk);
        ext_low[20] <= 0;
        $display("interrupt pin done");
    endtask
    task automatic t_ddc;
        wr(16'hff00, 8'h40);
        wr(16'hff01, 8'h45);
        a_pull <= 2'b10;
        d_pull <= 2'b01;
        settle;
        chk("first pair", 32'h1, {29'h0, p3_out[0], p3_oe[1:0]});
        chk("second pair", 32'h2, {30'h0, p5_oe[7:6]});
        @(posedge clk);
        a_pull <= 0;
        d_pull <= 0;
        ext_low[6] <= 1;
        settle;
        chk("digital sense", 32'h1, {30'h0, d_sense});
        wr(16'hff01, 8'h81);
        settle;
        chk("swapped sense", 32'h7, {28'h0, a_sense, d_sense});
        @(posedge clk);
        ext_low[6] <= 0;
        ext_low[18] <= 1;
        txd <= 0;
        wr(16'hff01, 8'h00);
        settle;
        chk("serial receive", 32'h0, {31'h0, rxd});
        chk("serial transmit", 32'h1, {31'h0, p3_oe[1]});
        @(posedge clk);
        ext_low[18] <= 0;
        txd <= 1;
        $display("ddc routing done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        end_of_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        t_reset;
        t_regs;
        t_pwm;
        t_analog;
        t_clock;
        t_irq;
        t_ddc;
        // second reset in mid-run must restore every register
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        t_reset;
        end_of_test;
    end
endmodule
